//--- src/sdtid_defines.svh
`ifndef SDTID_DEFINES_SVH
`define SDTID_DEFINES_SVH

// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define SDTID_OFF_TCFG 8'h00
`define SDTID_OFF_CTRL 8'h04
`define SDTID_OFF_BASE 8'h08
`define SDTID_OFF_MASK 8'h0c
`define SDTID_OFF_STAT 8'h10

// ------------------------------------------------------------
// timing config fields
// ------------------------------------------------------------
`define SDTID_RFC_HI 31
`define SDTID_RFC_LO 18
`define SDTID_WRL_HI 17
`define SDTID_WRL_LO 16
`define SDTID_APL_HI 15
`define SDTID_APL_LO 13
`define SDTID_RAS_HI 12
`define SDTID_RAS_LO 10
`define SDTID_CAS_HI 9
`define SDTID_CAS_LO 7
`define SDTID_PAL_HI 6
`define SDTID_PAL_LO 4
`define SDTID_ARL_HI 3
`define SDTID_ARL_LO 0
`define SDTID_TCFG_RST 32'h4003edf7

// ------------------------------------------------------------
// control, window and status fields
// ------------------------------------------------------------
`define SDTID_PWR_BIT 0
`define SDTID_ON_BIT 1
`define SDTID_WX_HI 31
`define SDTID_WX_LO 22
`define SDTID_WY_HI 15
`define SDTID_WY_LO 6
`define SDTID_WIN_RST 10'h000
`define SDTID_ST_PEND_BIT 0
`define SDTID_ST_BUSY_BIT 1
`define SDTID_ST_CNT_LO 18

// ------------------------------------------------------------
// sequence constants
// ------------------------------------------------------------
`define SDTID_PU_REFS 2'h2
`define SDTID_ARL_EXTRA 5'h01

`endif

//--- src/sdtid_pkg.sv
package sdtid_pkg;

   typedef enum logic [2:0] {
      SDTID_NOP,
      SDTID_ACTIVATE,
      SDTID_READ,
      SDTID_WRITE,
      SDTID_PRECHARGE,
      SDTID_PRECHARGE_ALL,
      SDTID_AUTO_REFRESH,
      SDTID_MODE_SET
   } sdtid_code_t;

   typedef enum {
      ST_IDLE,
      ST_PU_PRE,
      ST_PU_REF,
      ST_PU_MODE,
      ST_REF,
      ST_ACT,
      ST_RCD,
      ST_COL,
      ST_CAS,
      ST_PRE
   } sdtid_state_t;

   // command toward the memory devices
   typedef struct packed {
      sdtid_code_t code;
      logic dev_y;
      logic [1:0] bank;
      logic [2:0] cas;
   } sdtid_cmd_t;

   // access request from the system bus
   typedef struct packed {
      logic valid;
      logic we;
      logic [31:0] addr;
   } sdtid_sysreq_t;

endpackage : sdtid_pkg

//--- src/sdtid_downcnt.sv
`timescale 1ns/1ns
module sdtid_downcnt #(
   parameter int W = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic run,
   // state
   output logic [W-1:0] count,
   output logic zero
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } sdtid_cnt_t;

   sdtid_cnt_t s;
   sdtid_cnt_t next_s;

   always_comb begin
      next_s = s;
      if (load) begin
         next_s.cnt = load_val;
      end else if (run && s.cnt != '0) begin
         next_s.cnt = s.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign count = s.cnt;
   assign zero = (s.cnt == '0);
endmodule : sdtid_downcnt

//--- src/sdtid_window.sv
`timescale 1ns/1ns
module sdtid_window #(
   parameter int W = 10
) (
   // physical address top bits and window setup
   input wire logic [W-1:0] addr_top,
   input wire logic [W-1:0] base,
   input wire logic [W-1:0] mask,
   // decode result
   output logic hit
);
   // a zero mask bit drops that bit from the compare: mirrors or protection
   assign hit = (((addr_top ^ base) & mask) == '0);
endmodule : sdtid_window

//--- src/sdtid_top.sv
`timescale 1ns/1ns
`include "sdtid_defines.svh"
// How it works
// - 14-bit refresh down counter reloads, requests refresh
// - write recovery is field plus one cycles
// - active-to-precharge spacing from three-bit field
// - row-to-column spacing from three-bit field
// - column command to first data counts CAS
// - mode set carries CAS field unchanged
// - same-bank precharge delays activate and refresh
// - refresh blocks commands until counter expires
// - trigger reads one, clears at sequence end
// - only accesses inside window are served
// - cleared upper mask bits create mirrors
// - extra mask bits protect part of memory
// - decode uses physical bus address
// - base compares upper ten address bits
// - mask one compares, zero ignores bit
module sdtid_top
   import sdtid_pkg::*;
#(
   parameter int ADR_W = 8,
   parameter int BANK_LSB = 23
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // wishbone register slave
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [ADR_W-1:0] WB_ADR,
   input wire logic [3:0] WB_SEL,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK,
   // system access port
   input sdtid_sysreq_t SYS_REQ,
   output logic SYS_TAKEN,
   output logic SYS_DONE,
   // memory command port
   output sdtid_cmd_t SD_CMD
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [31:0] tcfg;
      logic power_up_trigger;
      logic on;
      logic [9:0] base_x;
      logic [9:0] base_y;
      logic [9:0] mask_x;
      logic [9:0] mask_y;
      logic ack;
      logic [31:0] dat_o;
      sdtid_state_t fsm;
      logic ref_pend;
      logic [1:0] pu_refs;
      logic dev_y;
      logic [1:0] bank;
      logic we;
      logic pre_valid;
      logic pre_all;
      logic pre_dev_y;
      logic [1:0] pre_bank;
      sdtid_cmd_t cmd;
      logic taken;
      logic done;
   } sdtid_regs_t;

   sdtid_regs_t s;
   sdtid_regs_t next_s;

   // ------------------------------------------------------------
   // field views
   // ------------------------------------------------------------
   logic [13:0] f_rfc;
   logic [1:0] f_wrl;
   logic [2:0] f_apl;
   logic [2:0] f_ras;
   logic [2:0] f_cas;
   logic [2:0] f_pal;
   logic [3:0] f_arl;

   assign f_rfc = s.tcfg[`SDTID_RFC_HI:`SDTID_RFC_LO];
   assign f_wrl = s.tcfg[`SDTID_WRL_HI:`SDTID_WRL_LO];
   assign f_apl = s.tcfg[`SDTID_APL_HI:`SDTID_APL_LO];
   assign f_ras = s.tcfg[`SDTID_RAS_HI:`SDTID_RAS_LO];
   assign f_cas = s.tcfg[`SDTID_CAS_HI:`SDTID_CAS_LO];
   assign f_pal = s.tcfg[`SDTID_PAL_HI:`SDTID_PAL_LO];
   assign f_arl = s.tcfg[`SDTID_ARL_HI:`SDTID_ARL_LO];

   // counter loaded at the command edge reaches zero N-1 cycles later,
   // so the next command lands N cycles after; zero codes are invalid anyway
   function automatic logic [2:0] span3(input logic [2:0] n);
      span3 = (n == 3'h0) ? 3'h0 : n - 3'h1;
   endfunction : span3

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
      merge = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            merge[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
   endfunction : merge

   // ------------------------------------------------------------
   // counters
   // ------------------------------------------------------------
   logic ld_tras, ld_trcd, ld_cas, ld_trp, ld_trfc, ld_twr, ld_rfsh;
   logic z_tras, z_trcd, z_cas, z_trp, z_trfc, z_twr, z_rfsh;
   logic [13:0] rfsh_count;
   logic [4:0] trfc_val;

   // auto refresh holds for field plus two cycles
   assign trfc_val = {1'b0, f_arl} + `SDTID_ARL_EXTRA;
   assign ld_rfsh = s.on && z_rfsh;

   sdtid_downcnt #(.W(14)) u_rfsh (
      .clk(MCLK), .rst(RST), .load(ld_rfsh), .load_val(f_rfc), .run(s.on),
      .count(rfsh_count), .zero(z_rfsh)
   );
   sdtid_downcnt #(.W(3)) u_tras (
      .clk(MCLK), .rst(RST), .load(ld_tras), .load_val(span3(f_apl)), .run(1'b1),
      .count(), .zero(z_tras)
   );
   sdtid_downcnt #(.W(3)) u_trcd (
      .clk(MCLK), .rst(RST), .load(ld_trcd), .load_val(span3(f_ras)), .run(1'b1),
      .count(), .zero(z_trcd)
   );
   sdtid_downcnt #(.W(3)) u_cas (
      .clk(MCLK), .rst(RST), .load(ld_cas), .load_val(span3(f_cas)), .run(1'b1),
      .count(), .zero(z_cas)
   );
   sdtid_downcnt #(.W(3)) u_trp (
      .clk(MCLK), .rst(RST), .load(ld_trp), .load_val(span3(f_pal)), .run(1'b1),
      .count(), .zero(z_trp)
   );
   sdtid_downcnt #(.W(5)) u_trfc (
      .clk(MCLK), .rst(RST), .load(ld_trfc), .load_val(trfc_val), .run(1'b1),
      .count(), .zero(z_trfc)
   );
   sdtid_downcnt #(.W(2)) u_twr (
      .clk(MCLK), .rst(RST), .load(ld_twr), .load_val(f_wrl), .run(1'b1),
      .count(), .zero(z_twr)
   );

   // ------------------------------------------------------------
   // window decode
   // ------------------------------------------------------------
   logic hit_x, hit_y;
   logic [1:0] req_bank;

   // the system port carries physical addresses only
   sdtid_window #(.W(10)) u_win_x (
      .addr_top(SYS_REQ.addr[31:22]), .base(s.base_x), .mask(s.mask_x), .hit(hit_x)
   );
   sdtid_window #(.W(10)) u_win_y (
      .addr_top(SYS_REQ.addr[31:22]), .base(s.base_y), .mask(s.mask_y), .hit(hit_y)
   );

   assign req_bank = SYS_REQ.addr[BANK_LSB +: 2];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic trp_block, cmd_ok;

   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      next_s.taken = 1'b0;
      next_s.done = 1'b0;
      next_s.cmd.code = SDTID_NOP;
      ld_tras = 1'b0;
      ld_trcd = 1'b0;
      ld_cas = 1'b0;
      ld_trp = 1'b0;
      ld_trfc = 1'b0;
      ld_twr = 1'b0;
      cmd_ok = z_trfc;
      // same bank and device, or every bank after a precharge-all; other banks go ahead at once
      trp_block = s.pre_valid && !z_trp &&
                  (s.pre_all || (s.pre_bank == req_bank && s.pre_dev_y == !hit_x));

      // a counter reaching zero sets pending; only the refresh clears it
      if (ld_rfsh) begin
         next_s.ref_pend = 1'b1;
      end
      if (z_trp) begin
         next_s.pre_valid = 1'b0;
      end

      case (s.fsm)
         ST_IDLE: begin
            if (!s.on) begin
               next_s.fsm = ST_IDLE;
            end else if (s.power_up_trigger) begin
               next_s.fsm = ST_PU_PRE;
            end else if (s.ref_pend) begin
               // banks are closed here; wait out any precharge spacing
               if (cmd_ok && (!s.pre_valid || z_trp) && z_twr) begin
                  next_s.fsm = ST_REF;
               end
            end else if (SYS_REQ.valid && (hit_x || hit_y) && cmd_ok && !trp_block) begin
               next_s.dev_y = !hit_x;
               next_s.bank = req_bank;
               next_s.we = SYS_REQ.we;
               next_s.taken = 1'b1;
               next_s.fsm = ST_ACT;
            end
         end
         ST_PU_PRE: begin
            if (cmd_ok) begin
               next_s.cmd.code = SDTID_PRECHARGE_ALL;
               ld_trp = 1'b1;
               next_s.pre_valid = 1'b1;
               next_s.pre_all = 1'b1;
               next_s.pu_refs = `SDTID_PU_REFS;
               next_s.fsm = ST_PU_REF;
            end
         end
         ST_PU_REF: begin
            if (s.pu_refs == 2'h0) begin
               next_s.fsm = ST_PU_MODE;
            end else if (cmd_ok && (!s.pre_valid || z_trp)) begin
               next_s.cmd.code = SDTID_AUTO_REFRESH;
               ld_trfc = 1'b1;
               next_s.pu_refs = s.pu_refs - 2'h1;
            end
         end
         ST_PU_MODE: begin
            if (cmd_ok) begin
               next_s.cmd.code = SDTID_MODE_SET;
               next_s.cmd.cas = f_cas;
               next_s.power_up_trigger = 1'b0;
               next_s.fsm = ST_IDLE;
            end
         end
         ST_REF: begin
            next_s.cmd.code = SDTID_AUTO_REFRESH;
            ld_trfc = 1'b1;
            if (!ld_rfsh) begin
               next_s.ref_pend = 1'b0;
            end
            next_s.fsm = ST_IDLE;
         end
         ST_ACT: begin
            next_s.cmd.code = SDTID_ACTIVATE;
            next_s.cmd.bank = s.bank;
            next_s.cmd.dev_y = s.dev_y;
            ld_tras = 1'b1;
            ld_trcd = 1'b1;
            next_s.fsm = ST_RCD;
         end
         ST_RCD: begin
            // column goes out on the expiry edge itself, else spacing is one long
            if (z_trcd) begin
               next_s.cmd.code = s.we ? SDTID_WRITE : SDTID_READ;
               ld_cas = 1'b1;
               next_s.fsm = ST_CAS;
            end
         end
         ST_CAS: begin
            if (z_cas) begin
               next_s.done = 1'b1;
               ld_twr = s.we;
               next_s.fsm = ST_PRE;
            end
         end
         ST_PRE: begin
            if (z_tras && z_twr && !ld_twr) begin
               next_s.cmd.code = SDTID_PRECHARGE;
               ld_trp = 1'b1;
               next_s.pre_valid = 1'b1;
               next_s.pre_all = 1'b0;
               next_s.pre_bank = s.bank;
               next_s.pre_dev_y = s.dev_y;
               next_s.fsm = ST_IDLE;
            end
         end
         default: begin
            next_s.fsm = ST_IDLE;
         end
      endcase

      // register slave; a write of one to the trigger beats the clear
      if (WB_CYC && WB_STB && !s.ack) begin
         next_s.ack = 1'b1;
         next_s.dat_o = 32'h0000_0000;
         case (WB_ADR)
            `SDTID_OFF_TCFG: begin
               next_s.dat_o = s.tcfg;
               if (WB_WE) begin
                  next_s.tcfg = merge(s.tcfg, WB_DAT_I, WB_SEL);
               end
            end
            `SDTID_OFF_CTRL: begin
               next_s.dat_o[`SDTID_PWR_BIT] = s.power_up_trigger;
               next_s.dat_o[`SDTID_ON_BIT] = s.on;
               if (WB_WE && WB_SEL[0]) begin
                  next_s.on = WB_DAT_I[`SDTID_ON_BIT];
                  if (WB_DAT_I[`SDTID_PWR_BIT]) begin
                     next_s.power_up_trigger = 1'b1;
                  end
               end
            end
            `SDTID_OFF_BASE: begin
               next_s.dat_o[`SDTID_WX_HI:`SDTID_WX_LO] = s.base_x;
               next_s.dat_o[`SDTID_WY_HI:`SDTID_WY_LO] = s.base_y;
               if (WB_WE && WB_SEL[3] && WB_SEL[2]) begin
                  next_s.base_x = WB_DAT_I[`SDTID_WX_HI:`SDTID_WX_LO];
               end
               if (WB_WE && WB_SEL[1] && WB_SEL[0]) begin
                  next_s.base_y = WB_DAT_I[`SDTID_WY_HI:`SDTID_WY_LO];
               end
            end
            `SDTID_OFF_MASK: begin
               next_s.dat_o[`SDTID_WX_HI:`SDTID_WX_LO] = s.mask_x;
               next_s.dat_o[`SDTID_WY_HI:`SDTID_WY_LO] = s.mask_y;
               if (WB_WE && WB_SEL[3] && WB_SEL[2]) begin
                  next_s.mask_x = WB_DAT_I[`SDTID_WX_HI:`SDTID_WX_LO];
               end
               if (WB_WE && WB_SEL[1] && WB_SEL[0]) begin
                  next_s.mask_y = WB_DAT_I[`SDTID_WY_HI:`SDTID_WY_LO];
               end
            end
            `SDTID_OFF_STAT: begin
               next_s.dat_o[`SDTID_ST_PEND_BIT] = s.ref_pend;
               next_s.dat_o[`SDTID_ST_BUSY_BIT] = (s.fsm != ST_IDLE);
               next_s.dat_o[31:`SDTID_ST_CNT_LO] = rfsh_count;
            end
            default: begin
               next_s.dat_o = 32'h0000_0000;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         s <= '0;
         s.tcfg <= `SDTID_TCFG_RST;
         s.base_x <= `SDTID_WIN_RST;
         s.base_y <= `SDTID_WIN_RST;
         s.mask_x <= `SDTID_WIN_RST;
         s.mask_y <= `SDTID_WIN_RST;
         s.fsm <= ST_IDLE;
         s.cmd.code <= SDTID_NOP;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign WB_DAT_O = s.dat_o;
   assign WB_ACK = s.ack;
   assign SYS_TAKEN = s.taken;
   assign SYS_DONE = s.done;
   assign SD_CMD = s.cmd;
endmodule : sdtid_top

//--- sim/sdtid_top_asserts.sv
`timescale 1ns/1ns
`include "sdtid_defines.svh"
module sdtid_top_asserts
   import sdtid_pkg::*;
#(
   parameter int ADR_W = 8
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // register bus
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [ADR_W-1:0] WB_ADR,
   input wire logic [3:0] WB_SEL,
   input wire logic [31:0] WB_DAT_I,
   input wire logic WB_ACK,
   // access and command
   input wire logic SYS_TAKEN,
   input wire logic SYS_DONE,
   input wire sdtid_cmd_t SD_CMD
);
   // ------------------------------------------------------------
   // shadow of timing config and command ages
   // ------------------------------------------------------------
   logic [31:0] tcfg;
   logic [7:0] act_age, col_age, done_age, pre_age, ref_age;
   logic last_wr, pre_all;
   logic [2:0] pre_bank;
   wire logic col = SD_CMD.code == SDTID_READ || SD_CMD.code == SDTID_WRITE;
   wire logic act = SD_CMD.code == SDTID_ACTIVATE;
   wire logic pre = SD_CMD.code == SDTID_PRECHARGE || SD_CMD.code == SDTID_PRECHARGE_ALL;
   wire logic aref = SD_CMD.code == SDTID_AUTO_REFRESH;
   wire logic same = pre_all || pre_bank == {SD_CMD.dev_y, SD_CMD.bank};
   function automatic logic [7:0] sat(input logic [7:0] a);
      return (a == 8'hff) ? a : a + 8'h01;
   endfunction : sat
   always_ff @(posedge MCLK) begin
      if (RST) begin
         tcfg <= `SDTID_TCFG_RST;
         {act_age, col_age, done_age, pre_age, ref_age} <= {5{8'hff}};
         {last_wr, pre_all, pre_bank} <= 5'h00;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (WB_CYC && WB_STB && WB_WE && !WB_ACK && WB_ADR == `SDTID_OFF_TCFG && WB_SEL[i]) begin
               tcfg[8*i +: 8] <= WB_DAT_I[8*i +: 8];
            end
         end
         act_age <= act ? 8'h01 : sat(act_age);
         col_age <= col ? 8'h01 : sat(col_age);
         done_age <= SYS_DONE ? 8'h01 : sat(done_age);
         pre_age <= pre ? 8'h01 : sat(pre_age);
         ref_age <= aref ? 8'h01 : sat(ref_age);
         if (col) begin
            last_wr <= SD_CMD.code == SDTID_WRITE;
         end
         if (pre) begin
            pre_all <= SD_CMD.code == SDTID_PRECHARGE_ALL;
            pre_bank <= {SD_CMD.dev_y, SD_CMD.bank};
         end
      end
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   AST_WB_ACK: assert property ((WB_CYC && WB_STB && !WB_ACK) |=> WB_ACK ##1 !WB_ACK)
      else $error("register ack not a single cycle after request");
   AST_TAKE_ACT: assert property (SYS_TAKEN |=> act)
      else $error("no activate after access taken");
   AST_WREC: assert property ((SD_CMD.code == SDTID_PRECHARGE && last_wr) |-> done_age >= {6'h00, tcfg[17:16]} + 8'h01 && done_age != 8'h00)
      else $error("precharge too soon after write data");
   AST_ACT_PRE: assert property ((SD_CMD.code == SDTID_PRECHARGE) |-> act_age >= {5'h00, tcfg[15:13]})
      else $error("precharge too soon after activate");
   AST_ROW_COL: assert property (col |-> act_age == {5'h00, tcfg[12:10]})
      else $error("column command spacing wrong");
   AST_CAS: assert property (SYS_DONE |-> col_age == {5'h00, tcfg[9:7]})
      else $error("first data not at column latency");
   AST_MODE: assert property ((SD_CMD.code == SDTID_MODE_SET) |-> SD_CMD.cas == tcfg[9:7])
      else $error("mode set latency differs from config");
   AST_PRE_ACT: assert property (((act && same) || aref) |-> pre_age >= {5'h00, tcfg[6:4]})
      else $error("bank reused too soon after precharge");
   AST_REF_BLOCK: assert property ((SD_CMD.code != SDTID_NOP) |-> ref_age >= {4'h0, tcfg[3:0]} + 8'h02)
      else $error("command issued inside refresh hold-off");
   AST_REF_CLOSED: assert property (aref |-> pre_age <= act_age)
      else $error("refresh issued with a bank open");
   COV_MODE: cover property (SD_CMD.code == SDTID_MODE_SET);
   COV_DONE: cover property (SYS_DONE && last_wr);
   COV_REF: cover property (aref);
endmodule : sdtid_top_asserts

//--- sim/sdtid_mem_model.sv
`timescale 1ns/1ns
module sdtid_mem_model
   import sdtid_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // commands from the controller
   input wire sdtid_cmd_t cmd,
   // observed memory state
   output logic [2:0] mode_cas,
   output logic [7:0] ref_cnt,
   output logic bad
);
   // one open flag per device and bank; misuse latches bad
   logic [7:0] open_bank;
   wire logic [2:0] idx = {cmd.dev_y, cmd.bank};
   always_ff @(posedge clk) begin
      if (rst) begin
         {open_bank, mode_cas, ref_cnt, bad} <= 20'h00000;
      end else begin
         case (cmd.code)
            SDTID_ACTIVATE: begin
               bad <= bad | open_bank[idx];
               open_bank[idx] <= 1'b1;
            end
            SDTID_READ, SDTID_WRITE: bad <= bad | !open_bank[idx];
            SDTID_PRECHARGE: open_bank[idx] <= 1'b0;
            SDTID_PRECHARGE_ALL: open_bank <= 8'h00;
            SDTID_AUTO_REFRESH: begin
               bad <= bad | (open_bank != 8'h00);
               ref_cnt <= ref_cnt + 8'h01;
            end
            SDTID_MODE_SET: mode_cas <= cmd.cas;
            default: ;
         endcase
      end
   end
endmodule : sdtid_mem_model

//--- sim/test_sdtid_top.sv
`timescale 1ns/1ns
module test_sdtid_top;
   import sdtid_pkg::*;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat_i = 32'h00000000, dat_o, rd;
   logic ack, taken, done, bad;
   sdtid_sysreq_t sys_req = '0;
   sdtid_cmd_t sd_cmd;
   logic [2:0] mode_cas;
   logic [7:0] ref_cnt, r0;
   int err_total = 0;
   int num_checks = 0;
   // mask, address, write, expected hit
   logic [31:0] tm [8] = '{32'hfe00ffc0, 32'hfe00ffc0, 32'hfe00ffc0, 32'hfe00ffc0,
      32'hfe00ffc0, 32'h7e00ffc0, 32'hff00ffc0, 32'hff00ffc0};
   logic [31:0] ta [8] = '{32'h50000010, 32'h51fffff0, 32'h52000000, 32'hd0000000,
      32'h80000040, 32'hd0000000, 32'h51000000, 32'h50fffff0};
   logic tw [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
   logic th [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
   always #4 MCLK = ~MCLK;
   sdtid_top dut (.MCLK(MCLK), .RST(RST), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
      .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK(ack),
      .SYS_REQ(sys_req), .SYS_TAKEN(taken), .SYS_DONE(done), .SD_CMD(sd_cmd));
   sdtid_mem_model mem (.clk(MCLK), .rst(RST), .cmd(sd_cmd), .mode_cas(mode_cas),
      .ref_cnt(ref_cnt), .bad(bad));
   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge MCLK);
      {cyc, stb, we, adr, dat_i, sel} <= {1'b1, 1'b1, w, a, d, s};
      n = 0;
      do begin
         @(posedge MCLK);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dat_o;
      if (ack !== 1'b1) err_total++;
      {cyc, stb, we} <= 3'h0;
   endtask : wb
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h00000000, 4'hf);
      check("register", rd, exp);
   endtask : rdc
   // held until taken; released address is inverted, not left stale
   task sys_access(input logic [31:0] a, input logic w, input logic hit);
      int n;
      @(posedge MCLK);
      sys_req <= '{1'b1, w, a};
      n = 0;
      do begin
         @(posedge MCLK);
         n++;
      end while (taken !== 1'b1 && n < 60);
      sys_req <= '{1'b0, 1'b0, ~a};
      check("taken", {31'h0, taken}, {31'h0, hit});
      if (taken === 1'b1) begin
         n = 0;
         do begin
            @(posedge MCLK);
            n++;
         end while (done !== 1'b1 && n < 60);
         check("data latency", n, 5);
      end
   endtask : sys_access
   task results;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      rdc(8'h00, 32'h4003edf7);
      rdc(8'h04, 32'h00000000);
      rdc(8'h0c, 32'h00000000);
      rdc(8'h14, 32'h00000000);
      rdc(8'h10, 32'h00000000);
      wb(1'b1, 8'h08, 32'hffffffff, 4'h4);
      rdc(8'h08, 32'h00000000);
      wb(1'b1, 8'h00, 32'hffffffff, 4'h1);
      rdc(8'h00, 32'h4003edff);
      // refresh 256, wrl 1, apl 5, ras 2, cas 2, pal 3, arl 3
      wb(1'b1, 8'h00, 32'h0401a933, 4'hf);
      rdc(8'h00, 32'h0401a933);
      wb(1'b1, 8'h08, 32'h50008000, 4'hf);
      rdc(8'h08, 32'h50008000);
      wb(1'b1, 8'h04, 32'h00000001, 4'h1);
      rdc(8'h04, 32'h00000001);
      repeat (20) @(posedge MCLK);
      wb(1'b1, 8'h04, 32'h00000003, 4'h1);
      for (int i = 0; i < 100 && rd[0] !== 1'b0; i++) begin
         wb(1'b0, 8'h04, 32'h00000000, 4'hf);
      end
      check("trigger", rd, 32'h00000002);
      check("mode cas", {29'h0, mode_cas}, 32'h00000002);
      check("power-up refreshes", {31'h0, ref_cnt >= 8'h02}, 32'h00000001);
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, 8'h0c, tm[i], 4'hf);
         sys_access(ta[i], tw[i], th[i]);
      end
      r0 = ref_cnt;
      repeat (600) @(posedge MCLK);
      r0 = ref_cnt - r0;
      check("refresh count", {31'h0, r0 >= 8'h02 && r0 <= 8'h03}, 32'h00000001);
      check("memory misuse", {31'h0, bad}, 32'h00000000);
      results();
   end
   initial begin
      repeat (30000) @(posedge MCLK);
      err_total++;
      results();
   end
endmodule : test_sdtid_top
bind sdtid_top sdtid_top_asserts #(.ADR_W(ADR_W)) chk (.MCLK(MCLK), .RST(RST), .WB_CYC(WB_CYC),
   .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I),
   .WB_ACK(WB_ACK), .SYS_TAKEN(SYS_TAKEN), .SYS_DONE(SYS_DONE), .SD_CMD(SD_CMD));
